//--- hw/ckp_defines.svh
// register offsets, field positions, reset values and timing figures of the clock controller
// assumes one includer per compilation unit may repeat the include; guarded
`ifndef CKP_DEFINES_SVH
`define CKP_DEFINES_SVH

`define CKP_ADDR_W          8
`define CKP_DATA_W          8

`define CKP_ADDR_POWER      8'h87
`define CKP_ADDR_OSC        8'h86
`define CKP_ADDR_SPEED      8'h8f
`define CKP_ADDR_SPEED_B    8'haf
`define CKP_ADDR_RELOAD     8'h97
`define CKP_ADDR_STATUS     8'hb0

`define CKP_POWER_IDLE_BIT  0
`define CKP_POWER_OFF_BIT   1
`define CKP_OSC_MAIN_EN_BIT 0
`define CKP_OSC_SUB_EN_BIT  1
`define CKP_OSC_SRC_BIT     2
`define CKP_SPEED_B_SPI_BIT 0

`define CKP_RELOAD_RST      8'hff
`define CKP_SPEED_RST_HI    7'h00
`define CKP_OSC_RST         3'h5

`define CKP_RELOAD_BYPASS   8'hff
`define CKP_RELOAD_TOP      10'h0ff
`define CKP_STD_PERIODS     4'hc
`define CKP_DS_PERIODS      4'h6
`define CKP_NUM_PERIPH      8

`endif

//--- hw/ckp_pkg.sv
// types and shared arithmetic of the clock controller
// assumes ckp_defines.svh is on the include path
`include "ckp_defines.svh"

package ckp_pkg;

    // speed control register, bit 7 down to bit 0
    typedef struct packed {
        logic two_wire_speed_sel;
        logic watchdog_speed_sel;
        logic counter_array_speed_sel;
        logic serial_speed_sel;
        logic timer2_speed_sel;
        logic timer1_speed_sel;
        logic timer0_speed_sel;
        logic double_speed;
    } ckp_speed_t;

    typedef struct packed {
        logic clock_source_select;
        logic sub_osc_enable;
        logic main_osc_enable;
    } ckp_osc_t;

    typedef struct packed {
        logic [`CKP_ADDR_W-1:0] addr;
        logic [`CKP_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } ckp_bus_t;

    // oscillator edges per prescaled tick
    function automatic logic [9:0] ckp_ratio(input logic [7:0] reload, input logic ds);
        logic [9:0] base;
        base = 10'h000;
        if (reload == `CKP_RELOAD_BYPASS) begin
            base = 10'h001;
        end else begin
            base = 10'((`CKP_RELOAD_TOP - {2'h0, reload}) << 1);
        end
        ckp_ratio = ds ? base : 10'(base << 1);
    endfunction

    // ticks per machine or peripheral cycle
    function automatic logic [3:0] ckp_cycle_len(input logic ds, input logic sel);
        ckp_cycle_len = (ds && !sel) ? `CKP_DS_PERIODS : `CKP_STD_PERIODS;
    endfunction

endpackage

//--- hw/ckp_prescaler.sv
// reload-value prescaler: one tick every ratio edges of the selected oscillator
// assumes osc_edge_i is a one-cycle pulse already in the sys_clk_i domain
`timescale 1ns/10ps
`include "ckp_defines.svh"

module ckp_prescaler (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       osc_edge_i,
    input  wire logic       run_i,
    input  wire logic [7:0] reload_i,
    input  wire logic       ds_i,
    output logic            tick_o
);

    logic [9:0] cnt;
    logic [9:0] ratio;

    assign ratio = ckp_pkg::ckp_ratio(reload_i, ds_i);

    // a reload written mid-count takes effect at once; a count at or past the new end wraps on the next edge
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt    <= 10'h000;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            tick_o <= 1'b0;
            if (run_i && osc_edge_i) begin
                if (cnt >= ratio - 10'h001) begin
                    cnt    <= 10'h000;
                    tick_o <= 1'b1;
                end else begin
                    cnt <= cnt + 10'h001;
                end
            end
        end
    end

    property p_tick_cause;
        @(posedge sys_clk_i) disable iff (rst_i)
        tick_o |-> $past(ce_i) && $past(run_i) && $past(osc_edge_i)
                   && $past(cnt) >= $past(ratio) - 10'h001;
    endproperty
    a_tick_cause: assert property (p_tick_cause) else $error("prescaler tick without full count");

    // a larger reload may end the current count at once, a smaller one never early
    property p_no_early_tick;
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i && run_i && osc_edge_i && cnt < ratio - 10'h001 |=> !tick_o;
    endproperty
    a_no_early_tick: assert property (p_no_early_tick) else $error("early prescaler tick");

endmodule

//--- hw/ckp_clock_ctrl.sv
// clock generation and speed control: oscillator gating, source select, prescaler, speed modes
// assumes oscillator inputs are asynchronous and well below half the system clock rate
`timescale 1ns/10ps
`include "ckp_defines.svh"

module ckp_clock_ctrl (
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    input  wire logic                   main_oscillator_i,
    input  wire logic                   sub_oscillator_i,
    input  wire logic                   hardware_security_byte_ds_i,
    input  wire logic                   wake_i,
    input  wire logic [`CKP_ADDR_W-1:0] addr_i,
    input  wire logic [`CKP_DATA_W-1:0] wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [`CKP_DATA_W-1:0] rdata_o,
    output logic                        main_osc_stop_o,
    output logic                        sub_osc_stop_o,
    output logic                        clk_out_o,
    output logic                        cpu_tick_o,
    output logic                        periph_tick_o,
    output logic                        machine_cycle_o,
    output logic [`CKP_NUM_PERIPH-1:0]  periph_cycle_o,
    output logic                        cpu_frozen_o,
    output logic                        ram_retain_o
);

    ckp_pkg::ckp_bus_t   bus;
    ckp_pkg::ckp_speed_t speed;
    ckp_pkg::ckp_osc_t   osc;
    logic                power_down;
    logic                idle;
    logic [7:0]          reload;
    logic                spi_speed_sel;

    logic [2:0]          main_sync;
    logic [2:0]          sub_sync;
    logic [1:0]          sec_sync;
    logic                main_edge;
    logic                sub_edge;
    logic                sel_edge;
    logic                pre_tick;
    logic                cpu_run;
    logic                periph_run;

    logic [3:0]          mc_cnt;
    logic [3:0]          pc_cnt [`CKP_NUM_PERIPH];
    logic [`CKP_NUM_PERIPH-1:0] periph_sel;
    logic [`CKP_DATA_W-1:0]     next_rdata;

    assign bus.addr  = addr_i;
    assign bus.wdata = wdata_i;
    assign bus.wr    = wr_i;
    assign bus.rd    = rd_i;

    // oscillator pins and the strap are asynchronous; sync[0] feeds only sync[1]
    always_ff @(posedge sys_clk_i) begin
        if (ce_i) begin
            main_sync <= {main_sync[1:0], main_oscillator_i};
            sub_sync  <= {sub_sync[1:0], sub_oscillator_i};
            sec_sync  <= {sec_sync[0], hardware_security_byte_ds_i};
        end
    end

    assign main_edge = main_sync[1] && !main_sync[2];
    assign sub_edge  = sub_sync[1] && !sub_sync[2];

    // a stopped oscillator delivers no edges even if the pin still toggles
    assign sel_edge = osc.clock_source_select ? (main_edge && !main_osc_stop_o)
                                              : (sub_edge && !sub_osc_stop_o);

    assign cpu_run    = !power_down && !idle;
    assign periph_run = !power_down;

    // power control: software writes both bits, wake clears idle, a write of zero or reset clears power-down
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            power_down <= 1'b0;
            idle       <= 1'b0;
        end else if (ce_i) begin
            if (bus.wr && bus.addr == `CKP_ADDR_POWER) begin
                power_down <= bus.wdata[`CKP_POWER_OFF_BIT];
                idle       <= bus.wdata[`CKP_POWER_IDLE_BIT];
            end else if (wake_i) begin
                idle <= 1'b0;
            end
        end
    end

    // oscillator enables and source select; reset runs on main only
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            osc <= `CKP_OSC_RST;
        end else if (ce_i && bus.wr && bus.addr == `CKP_ADDR_OSC) begin
            osc.main_osc_enable     <= bus.wdata[`CKP_OSC_MAIN_EN_BIT];
            osc.sub_osc_enable      <= bus.wdata[`CKP_OSC_SUB_EN_BIT];
            osc.clock_source_select <= bus.wdata[`CKP_OSC_SRC_BIT];
        end
    end

    // speed control: bit 0 follows the security strap at reset
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            speed[7:1]        <= `CKP_SPEED_RST_HI;
            speed.double_speed <= sec_sync[1];
        end else if (ce_i && bus.wr && bus.addr == `CKP_ADDR_SPEED) begin
            speed <= bus.wdata;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            spi_speed_sel <= 1'b0;
        end else if (ce_i && bus.wr && bus.addr == `CKP_ADDR_SPEED_B) begin
            spi_speed_sel <= bus.wdata[`CKP_SPEED_B_SPI_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reload <= `CKP_RELOAD_RST;
        end else if (ce_i && bus.wr && bus.addr == `CKP_ADDR_RELOAD) begin
            reload <= bus.wdata;
        end
    end

    // oscillator hard block controls
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            main_osc_stop_o <= 1'b0;
            sub_osc_stop_o  <= 1'b1;
        end else if (ce_i) begin
            main_osc_stop_o <= power_down || !osc.main_osc_enable;
            sub_osc_stop_o  <= power_down || !osc.sub_osc_enable;
        end
    end

    // undivided clock follows the selected oscillator
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            clk_out_o <= 1'b0;
        end else if (ce_i) begin
            clk_out_o <= osc.clock_source_select ? main_sync[1] : sub_sync[1];
        end
    end

    ckp_prescaler u_prescaler (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .osc_edge_i (sel_edge),
        .run_i      (periph_run),
        .reload_i   (reload),
        .ds_i       (speed.double_speed),
        .tick_o     (pre_tick)
    );

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cpu_tick_o    <= 1'b0;
            periph_tick_o <= 1'b0;
            cpu_frozen_o  <= 1'b0;
            ram_retain_o  <= 1'b0;
        end else if (ce_i) begin
            cpu_tick_o    <= pre_tick && cpu_run;
            periph_tick_o <= pre_tick && periph_run;
            cpu_frozen_o  <= !cpu_run;
            ram_retain_o  <= power_down;
        end
    end

    // machine cycle: 12 or 6 prescaled ticks
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mc_cnt          <= 4'h0;
            machine_cycle_o <= 1'b0;
        end else if (ce_i) begin
            machine_cycle_o <= 1'b0;
            if (pre_tick && cpu_run) begin
                if (mc_cnt >= ckp_pkg::ckp_cycle_len(speed.double_speed, 1'b0) - 4'h1) begin
                    mc_cnt          <= 4'h0;
                    machine_cycle_o <= 1'b1;
                end else begin
                    mc_cnt <= mc_cnt + 4'h1;
                end
            end
        end
    end

    // order: timer0, timer1, timer2, serial, counter array, watchdog, 2-wire, spi
    assign periph_sel = {spi_speed_sel, speed.two_wire_speed_sel, speed.watchdog_speed_sel,
                         speed.counter_array_speed_sel, speed.serial_speed_sel,
                         speed.timer2_speed_sel, speed.timer1_speed_sel, speed.timer0_speed_sel};

    // selectors pass through ckp_cycle_len, which ignores them without double speed
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `CKP_NUM_PERIPH; i++) begin
                pc_cnt[i] <= 4'h0;
            end
            periph_cycle_o <= '0;
        end else if (ce_i) begin
            periph_cycle_o <= '0;
            if (pre_tick && periph_run) begin
                for (int i = 0; i < `CKP_NUM_PERIPH; i++) begin
                    if (pc_cnt[i] >= ckp_pkg::ckp_cycle_len(speed.double_speed,
                                                            periph_sel[i]) - 4'h1) begin
                        pc_cnt[i]         <= 4'h0;
                        periph_cycle_o[i] <= 1'b1;
                    end else begin
                        pc_cnt[i] <= pc_cnt[i] + 4'h1;
                    end
                end
            end
        end
    end

    // read data stands one cycle after the strobe only; unmapped reads give zero
    always_comb begin
        next_rdata = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                `CKP_ADDR_POWER:   next_rdata = {6'h00, power_down, idle};
                `CKP_ADDR_OSC:     next_rdata = {5'h00, osc};
                `CKP_ADDR_SPEED:   next_rdata = speed;
                `CKP_ADDR_SPEED_B: next_rdata = {7'h00, spi_speed_sel};
                `CKP_ADDR_RELOAD:  next_rdata = reload;
                `CKP_ADDR_STATUS:  next_rdata = {4'h0, power_down, cpu_frozen_o,
                                                 sub_osc_stop_o, main_osc_stop_o};
                default:           next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= next_rdata;
        end
    end

    // checks

    sequence s_idle_sub;
        !power_down && idle && osc.sub_osc_enable && !osc.clock_source_select;
    endsequence

    sequence s_prescaler_fires;
        pre_tick && ce_i;
    endsequence

    property p_idle_sub;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_idle_sub ##0 s_prescaler_fires |=> !cpu_tick_o && periph_tick_o;
    endproperty
    a_idle_sub: assert property (p_idle_sub) else $error("idle on sub clock wrong");

    property p_power_down;
        @(posedge sys_clk_i) disable iff (rst_i)
        power_down && ce_i |=> !cpu_tick_o && !periph_tick_o && main_osc_stop_o && sub_osc_stop_o;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power-down left a clock running");

    property p_main_stop;
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i |=> main_osc_stop_o == ($past(power_down) || !$past(osc.main_osc_enable));
    endproperty
    a_main_stop: assert property (p_main_stop) else $error("main stop mismatch");

    property p_sub_stop;
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i |=> sub_osc_stop_o == ($past(power_down) || !$past(osc.sub_osc_enable));
    endproperty
    a_sub_stop: assert property (p_sub_stop) else $error("sub stop mismatch");

    property p_reset_reload;
        @(posedge sys_clk_i)
        rst_i |=> reload == `CKP_RELOAD_RST && speed[7:1] == `CKP_SPEED_RST_HI;
    endproperty
    a_reset_reload: assert property (p_reset_reload) else $error("reset values wrong");

    property p_reset_x2;
        @(posedge sys_clk_i)
        rst_i |=> speed.double_speed == $past(sec_sync[1]);
    endproperty
    a_reset_x2: assert property (p_reset_x2) else $error("double speed not from strap");

    property p_clk_out;
        @(posedge sys_clk_i) disable iff (rst_i)
        ce_i |=> clk_out_o == ($past(osc.clock_source_select) ? $past(main_sync[1])
                                                              : $past(sub_sync[1]));
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("clock output not the selected source");

    property p_idle_periph;
        @(posedge sys_clk_i) disable iff (rst_i)
        idle && !power_down ##0 s_prescaler_fires |=> periph_tick_o && cpu_frozen_o;
    endproperty
    a_idle_periph: assert property (p_idle_periph) else $error("idle stopped peripherals");

    property p_std_periph;
        @(posedge sys_clk_i) disable iff (rst_i)
        !speed.double_speed && ce_i |=> pc_cnt[0] < `CKP_STD_PERIODS && mc_cnt < `CKP_STD_PERIODS;
    endproperty
    a_std_periph: assert property (p_std_periph) else $error("cycle count out of range");

    property p_retain;
        @(posedge sys_clk_i) disable iff (rst_i)
        power_down && ce_i |=> ram_retain_o;
    endproperty
    a_retain: assert property (p_retain) else $error("retain not raised in power-down");

    // a clear selector must not shorten the cycle while double speed is off
    property p_std_sel;
        @(posedge sys_clk_i) disable iff (rst_i)
        !speed.double_speed && periph_run && pc_cnt[0] == `CKP_DS_PERIODS - 4'h1
            ##0 s_prescaler_fires |=> !periph_cycle_o[0];
    endproperty
    a_std_sel: assert property (p_std_sel) else $error("selector used in std mode");

    property p_fast_cycle;
        @(posedge sys_clk_i) disable iff (rst_i)
        speed.double_speed && !periph_sel[0] && periph_run
            && pc_cnt[0] == `CKP_DS_PERIODS - 4'h1 ##0 s_prescaler_fires |=> periph_cycle_o[0];
    endproperty
    a_fast_cycle: assert property (p_fast_cycle) else $error("fast peripheral cycle late");

    property p_mc_fast;
        @(posedge sys_clk_i) disable iff (rst_i)
        speed.double_speed && cpu_run && mc_cnt == `CKP_DS_PERIODS - 4'h1 ##0 s_prescaler_fires
            |=> machine_cycle_o;
    endproperty
    a_mc_fast: assert property (p_mc_fast) else $error("machine cycle not 6 ticks");

endmodule

//--- verif/ckp_clock_ctrl_bench.sv
// self-checking bench of the clock controller: register port, oscillator gating, dividers
// assumes the design asserts itself; oscillators here stop while their stop output is high
`timescale 1ns/10ps
`include "ckp_defines.svh"

module ckp_clock_ctrl_bench;
    logic       sys_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       ce_i = 1'b1;
    logic       main_oscillator_i = 1'b0;
    logic       sub_oscillator_i = 1'b0;
    logic       strap = 1'b0;
    logic       wake_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic       main_osc_stop_o;
    logic       sub_osc_stop_o;
    logic       clk_out_o;
    logic       cpu_tick_o;
    logic       periph_tick_o;
    logic       machine_cycle_o;
    logic [7:0] periph_cycle_o;
    logic       cpu_frozen_o;
    logic       ram_retain_o;
    logic       clk_prev = 1'b0;
    logic [11:0] probe;
    logic [2:0] m_cnt = 3'h0;
    logic [2:0] s_cnt = 3'h0;
    int         failures = 0;
    int         compares = 0;

    // probe index: 0 cpu tick, 1 periph tick, 2 machine cycle, 3..10 periph cycles, 11 clk out rise
    assign probe = {clk_out_o & ~clk_prev, periph_cycle_o, machine_cycle_o, periph_tick_o,
                    cpu_tick_o};

    ckp_clock_ctrl u_dut (
        .sys_clk_i                   (sys_clk_i),
        .rst_i                       (rst_i),
        .ce_i                        (ce_i),
        .main_oscillator_i           (main_oscillator_i),
        .sub_oscillator_i            (sub_oscillator_i),
        .hardware_security_byte_ds_i (strap),
        .wake_i                      (wake_i),
        .addr_i                      (addr_i),
        .wdata_i                     (wdata_i),
        .wr_i                        (wr_i),
        .rd_i                        (rd_i),
        .rdata_o                     (rdata_o),
        .main_osc_stop_o             (main_osc_stop_o),
        .sub_osc_stop_o              (sub_osc_stop_o),
        .clk_out_o                   (clk_out_o),
        .cpu_tick_o                  (cpu_tick_o),
        .periph_tick_o               (periph_tick_o),
        .machine_cycle_o             (machine_cycle_o),
        .periph_cycle_o              (periph_cycle_o),
        .cpu_frozen_o                (cpu_frozen_o),
        .ram_retain_o                (ram_retain_o)
    );

    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    // main period 8 cycles, sub period 12; a halted oscillator sits low
    always @(posedge sys_clk_i) begin
        clk_prev <= clk_out_o;
        m_cnt <= (m_cnt == 3'h3) ? 3'h0 : m_cnt + 3'h1;
        s_cnt <= (s_cnt == 3'h5) ? 3'h0 : s_cnt + 3'h1;
        if (m_cnt == 3'h3) begin
            main_oscillator_i <= ~main_oscillator_i & ~main_osc_stop_o;
        end
        if (s_cnt == 3'h5) begin
            sub_oscillator_i <= ~sub_oscillator_i & ~sub_osc_stop_o;
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic do_reset(input logic s);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        strap <= s;
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(posedge sys_clk_i);
        check(name, {8'h00, exp}, {8'h00, rdata_o});
    endtask

    // bounded wait for a pulse on one probe bit; n is the number of edges waited
    task automatic wait_pulse(input int idx, output int n);
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (probe[idx] !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            failures++;
            $display("[FAIL] wait on probe %0d expected pulse seen none", idx);
            report_and_stop();
        end
    endtask

    // skip to a pulse and past one more interval, then time one full interval
    task automatic measure(input int idx, input int exp, input string name);
        int n;
        wait_pulse(idx, n);
        wait_pulse(idx, n);
        wait_pulse(idx, n);
        check(name, exp[15:0], n[15:0]);
    endtask

    task automatic count_pulses(input int idx, input int cycles, output int n);
        n = 0;
        repeat (cycles) begin
            @(posedge sys_clk_i);
            if (probe[idx] === 1'b1) n++;
        end
    endtask

    task automatic t_reset();
        chk_rd(`CKP_ADDR_SPEED, 8'h00, "speed after reset");
        chk_rd(`CKP_ADDR_RELOAD, 8'hff, "reload after reset");
        chk_rd(`CKP_ADDR_OSC, 8'h05, "osc ctrl after reset");
        chk_rd(8'h80, 8'h00, "unmapped read");
        check("main stop", 16'h0, {15'h0, main_osc_stop_o});
        check("sub stop", 16'h1, {15'h0, sub_osc_stop_o});
        measure(0, 16, "cpu tick main div2");
        measure(1, 16, "periph tick main div2");
        wr(`CKP_ADDR_SPEED, 8'ha5);
        chk_rd(`CKP_ADDR_SPEED, 8'ha5, "speed readback");
        wr(`CKP_ADDR_SPEED, 8'h00);
        $display("test reset and registers done");
    endtask

    task automatic t_prescale();
        logic [7:0] rl [6] = '{8'hff, 8'hff, 8'hfe, 8'hfe, 8'h00, 8'h00};
        int         ex [6] = '{16, 8, 32, 16, 8160, 4080};
        for (int i = 0; i < 6; i++) begin
            wr(`CKP_ADDR_RELOAD, rl[i]);
            wr(`CKP_ADDR_SPEED, {7'h00, 1'(i % 2)});
            measure(0, ex[i], "cpu tick interval");
        end
        wr(`CKP_ADDR_RELOAD, 8'hff);
        wr(`CKP_ADDR_SPEED, 8'h00);
        measure(2, 192, "machine cycle std");
        wr(`CKP_ADDR_SPEED, 8'h01);
        measure(2, 48, "machine cycle double");
        $display("test prescaler done");
    endtask

    task automatic t_periph();
        for (int b = 0; b < 8; b++) begin
            wr(`CKP_ADDR_SPEED, 8'h01);
            wr(`CKP_ADDR_SPEED_B, 8'h00);
            measure(3 + b, 48, "periph cycle fast");
            wr(`CKP_ADDR_SPEED, 8'hff);
            wr(`CKP_ADDR_SPEED_B, 8'h01);
            chk_rd(`CKP_ADDR_SPEED_B, 8'h01, "spi speed readback");
            measure(3 + b, 96, "periph cycle double slow");
            // selectors clear: only the missing double speed keeps the cycle long
            wr(`CKP_ADDR_SPEED, 8'h00);
            wr(`CKP_ADDR_SPEED_B, 8'h00);
            measure(3 + b, 192, "periph cycle std");
        end
        wr(`CKP_ADDR_SPEED, 8'h00);
        wr(`CKP_ADDR_SPEED_B, 8'h00);
        $display("test peripheral speed done");
    endtask

    task automatic t_osc();
        for (int v = 0; v < 4; v++) begin
            wr(`CKP_ADDR_OSC, {5'h00, 1'b1, 2'(v)});
            check("main stop", {15'h0, ~v[0]}, {15'h0, main_osc_stop_o});
            check("sub stop", {15'h0, ~v[1]}, {15'h0, sub_osc_stop_o});
        end
        measure(11, 8, "clk out main");
        wr(`CKP_ADDR_OSC, 8'h03);
        measure(11, 12, "clk out sub");
        measure(0, 24, "cpu tick sub div2");
        $display("test oscillators done");
    endtask

    task automatic t_idle();
        int n;
        wr(`CKP_ADDR_OSC, 8'h02);
        wr(`CKP_ADDR_POWER, 8'h01);
        check("frozen", 16'h1, {15'h0, cpu_frozen_o});
        chk_rd(`CKP_ADDR_STATUS, 8'h05, "status idle");
        chk_rd(`CKP_ADDR_POWER, 8'h01, "power reg idle");
        measure(1, 24, "periph tick idle");
        count_pulses(0, 300, n);
        check("cpu ticks idle", 16'h0, n[15:0]);
        @(posedge sys_clk_i);
        wake_i <= 1'b1;
        @(posedge sys_clk_i);
        wake_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        check("frozen after wake", 16'h0, {15'h0, cpu_frozen_o});
        measure(0, 24, "cpu tick after wake");
        $display("test idle done");
    endtask

    task automatic t_pwrdn();
        int n;
        wr(`CKP_ADDR_OSC, 8'h07);
        wr(`CKP_ADDR_POWER, 8'h02);
        chk_rd(`CKP_ADDR_STATUS, 8'h0f, "status power down");
        check("ram retain", 16'h1, {15'h0, ram_retain_o});
        count_pulses(1, 300, n);
        check("periph ticks power down", 16'h0, n[15:0]);
        wr(`CKP_ADDR_POWER, 8'h00);
        check("ram retain off", 16'h0, {15'h0, ram_retain_o});
        measure(1, 16, "periph tick resumed");
        $display("test power down done");
    endtask

    initial begin
        do_reset(1'b0);
        t_reset();
        t_prescale();
        t_periph();
        t_osc();
        t_idle();
        t_pwrdn();
        do_reset(1'b1);
        chk_rd(`CKP_ADDR_SPEED, 8'h01, "speed strap");
        measure(2, 48, "machine cycle strap");
        $display("test strap done");
        report_and_stop();
    end
endmodule
